// file: cipc_ctrl.sv
// event flags, power reduction and command control of the contactless unit
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "cipc_defines.svh"

module cipc_ctrl
#(
  parameter int PD_EXIT_CYCLES = `CIPC_PD_EXIT_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reset_powerdown_n,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [15:0] timer_value,
  input wire logic tx_in_payload,
  input wire logic tx_in_eof,
  input wire logic rx_stream_end,
  input wire logic crc_fifo_consumed,
  input wire logic [6:0] fifo_level,
  input wire logic field_present,
  input wire logic [7:0] error_reg,
  input wire logic mode_detected,
  input wire logic cmd_done,
  output logic high_prio_summary,
  output logic low_prio_summary,
  output logic checksum_ready,
  output logic [3:0] active_cmd,
  output logic cmd_start,
  output logic cmd_abort,
  output logic cmd_run,
  output logic [1:0] driver_field_on,
  output logic [7:0] carrier_n_conductance,
  output logic [7:0] mod_n_conductance,
  output logic [5:0] carrier_p_conductance,
  output logic [5:0] mod_p_conductance,
  output logic units_on,
  output logic level_detector_on,
  output logic receiver_on
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  localparam cipc_pkg::cipc_state_t RST_S = '{pwr: cipc_pkg::PWR_RUN, default: '0};
  localparam logic [10:0] EXIT_LAST = 11'(PD_EXIT_CYCLES - 1);

  cipc_pkg::cipc_state_t s_ff; // registered state
  cipc_pkg::cipc_state_t nxt_s; // next state
  logic hi_alert; // fifo nearly full
  logic lo_alert; // fifo nearly empty
  logic ev_on; // event logic running
  logic cmd_wr; // write to command register
  logic [6:0] comm_set; // hardware sets of comm events
  logic [4:0] misc_set; // hardware sets of misc events
  logic [6:0] need_args; // argument bytes the command waits for

  ////////////////////////////////////////////////////////////////////////////
  // fifo alerts from the fill count
  always_comb
  begin
    hi_alert = (`CIPC_FIFO_DEPTH - fifo_level) <= {1'b0, s_ff.watermark};
    lo_alert = fifo_level <= {1'b0, s_ff.watermark};
  end

  ////////////////////////////////////////////////////////////////////////////
  // hardware event detection: rising edges, except timer on a one-to-zero step, tx on payload-to-eof, idle on done, field-off on a falling edge
  always_comb
  begin
    // blocks stand still in either power-down; detector only in hard one
    ev_on = reset_powerdown_n && (s_ff.pwr == cipc_pkg::PWR_RUN);
    comm_set = '0;
    misc_set = '0;
    comm_set[`CIPC_EV_TIMER] = ev_on && (s_ff.timer_prev == 16'h0001)
      && (timer_value == 16'h0000);
    comm_set[`CIPC_EV_TX] = ev_on && s_ff.payload_prev && tx_in_eof;
    comm_set[`CIPC_EV_RX] = ev_on && rx_stream_end && !s_ff.rx_end_prev;
    comm_set[`CIPC_EV_IDLE] = ev_on && cmd_done && (s_ff.cmd != `CIPC_CMD_IDLE);
    comm_set[`CIPC_EV_HI] = ev_on && hi_alert && !s_ff.hi_prev;
    comm_set[`CIPC_EV_LO] = ev_on && lo_alert && !s_ff.lo_prev;
    comm_set[`CIPC_EV_ERROR] = ev_on && (|error_reg) && !s_ff.err_prev;
    misc_set[`CIPC_DV_CHECKSUM] = ev_on && crc_fifo_consumed && !s_ff.crc_prev;
    misc_set[`CIPC_DV_MODE] = ev_on && mode_detected && !s_ff.mode_prev;
    // level detector keeps running in unit power-down
    misc_set[`CIPC_DV_FIELD_ON] = reset_powerdown_n && field_present
      && !s_ff.field_prev;
    misc_set[`CIPC_DV_FIELD_OFF] = reset_powerdown_n && !field_present
      && s_ff.field_prev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // argument count a command waits for; only config has a fixed set
  always_comb
  begin
    case (s_ff.cmd)
      `CIPC_CMD_CONFIG: need_args = `CIPC_CONFIG_ARGS;
      default: need_args = 7'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    nxt_s = s_ff;
    cmd_wr = wr_en && (addr == `CIPC_OFS_COMMAND);
    nxt_s.start = 1'b0;
    nxt_s.abort = 1'b0;

    // source history, kept only while the sources run
    if (ev_on)
    begin
      nxt_s.timer_prev = timer_value;
      nxt_s.payload_prev = tx_in_payload;
      nxt_s.rx_end_prev = rx_stream_end;
      nxt_s.crc_prev = crc_fifo_consumed;
      nxt_s.hi_prev = hi_alert;
      nxt_s.lo_prev = lo_alert;
      nxt_s.err_prev = |error_reg;
      nxt_s.mode_prev = mode_detected;
    end
    if (reset_powerdown_n)
    begin
      nxt_s.field_prev = field_present;
    end

    // engine finished: command falls back to idle
    if (ev_on && cmd_done)
    begin
      nxt_s.cmd = `CIPC_CMD_IDLE;
    end

    // software writes; registers otherwise hold in any power state
    if (wr_en)
    begin
      case (addr)
        `CIPC_OFS_COMMAND:
        begin
          // fifo is left untouched here so arguments may come first
          if (wdata[3:0] != `CIPC_CMD_NO_CHANGE)
          begin
            nxt_s.cmd = wdata[3:0];
            nxt_s.abort = (s_ff.cmd != `CIPC_CMD_IDLE);
            nxt_s.start = (wdata[3:0] != `CIPC_CMD_IDLE);
          end
        end
        `CIPC_OFS_COMM_IEN: nxt_s.comm_ien = wdata[6:0];
        `CIPC_OFS_MISC_IEN: nxt_s.misc_ien = wdata[4:0];
        `CIPC_OFS_COMM_EVENT:
        begin
          // bit 7 chooses set or clear of the written ones
          if (wdata[`CIPC_EV_SET_BIT])
            nxt_s.comm_ev = s_ff.comm_ev | wdata[6:0];
          else
            nxt_s.comm_ev = s_ff.comm_ev & ~wdata[6:0];
        end
        `CIPC_OFS_MISC_EVENT:
        begin
          if (wdata[`CIPC_EV_SET_BIT])
            nxt_s.misc_ev = s_ff.misc_ev | wdata[4:0];
          else
            nxt_s.misc_ev = s_ff.misc_ev & ~wdata[4:0];
        end
        `CIPC_OFS_WATERMARK: nxt_s.watermark = wdata[5:0];
        `CIPC_OFS_BIT_FRAMING: nxt_s.start_send = wdata[`CIPC_START_SEND_BIT];
        `CIPC_OFS_TX_CONTROL: nxt_s.drv_en = wdata[1:0];
        `CIPC_OFS_DRV_SELECT: nxt_s.drv_sel = wdata[5:4];
        `CIPC_OFS_TX_AUTO: nxt_s.auto_wake = wdata[`CIPC_AUTO_WAKE_BIT];
        `CIPC_OFS_CARRIER_N: nxt_s.cn_gs = wdata;
        `CIPC_OFS_MOD_N: nxt_s.mn_gs = wdata;
        `CIPC_OFS_CARRIER_P: nxt_s.cp_gs = wdata[5:0];
        `CIPC_OFS_MOD_P: nxt_s.mp_gs = wdata[5:0];
        default:
        begin
          // unmapped or read-only: ignored
        end
      endcase
    end

    // hardware sets win over a clear in the same cycle
    nxt_s.comm_ev = nxt_s.comm_ev | comm_set;
    nxt_s.misc_ev = nxt_s.misc_ev | misc_set;

    // power state machine
    case (s_ff.pwr)
      cipc_pkg::PWR_RUN:
      begin
        if (cmd_wr && wdata[`CIPC_CMD_PD_BIT])
          nxt_s.pwr = cipc_pkg::PWR_DOWN;
      end
      cipc_pkg::PWR_DOWN:
      begin
        if (s_ff.auto_wake && misc_set[`CIPC_DV_FIELD_ON])
          nxt_s.pwr = cipc_pkg::PWR_RUN;
        else if (cmd_wr && !wdata[`CIPC_CMD_PD_BIT])
        begin
          nxt_s.pwr = cipc_pkg::PWR_EXIT;
          nxt_s.exit_cnt = 11'h000;
        end
      end
      cipc_pkg::PWR_EXIT:
      begin
        // bit keeps reading one for the whole wait
        if (cmd_wr && wdata[`CIPC_CMD_PD_BIT])
          nxt_s.pwr = cipc_pkg::PWR_DOWN;
        else if (s_ff.auto_wake && misc_set[`CIPC_DV_FIELD_ON])
          nxt_s.pwr = cipc_pkg::PWR_RUN;
        else if (s_ff.exit_cnt == EXIT_LAST)
          nxt_s.pwr = cipc_pkg::PWR_RUN;
        else
          nxt_s.exit_cnt = s_ff.exit_cnt + 11'h001;
      end
      default: nxt_s.pwr = cipc_pkg::PWR_RUN;
    endcase

    // registered outputs follow the next state
    nxt_s.units_on = reset_powerdown_n && (nxt_s.pwr == cipc_pkg::PWR_RUN);
    nxt_s.det_on = reset_powerdown_n;
    nxt_s.crc_ready = nxt_s.misc_ev[`CIPC_DV_CHECKSUM];
    nxt_s.hi_sum = |(nxt_s.comm_ev & nxt_s.comm_ien & `CIPC_HI_COMM_MASK);
    nxt_s.lo_sum = |(nxt_s.comm_ev & nxt_s.comm_ien & `CIPC_LO_COMM_MASK)
      | |(nxt_s.misc_ev & nxt_s.misc_ien & `CIPC_LO_MISC_MASK);
    // transceive sends only once start-send is set; config waits for its arguments, others go at once
    nxt_s.run = nxt_s.units_on && (nxt_s.cmd != `CIPC_CMD_IDLE)
      && ((nxt_s.cmd != `CIPC_CMD_TRANSCEIVE) || nxt_s.start_send)
      && (fifo_level >= need_args) && ((need_args == 7'h00) || (fifo_level == need_args));
    // drivers off: field gone, receiver stays on with the unit
    nxt_s.drv_out = nxt_s.units_on ? nxt_s.drv_en : 2'h0;
    nxt_s.cn_out = nxt_s.cn_gs;
    nxt_s.mn_out = nxt_s.mn_gs;
    nxt_s.cp_out = nxt_s.cp_gs;
    nxt_s.mp_out = nxt_s.mp_gs;
    // low output impedance in power-down when drv_sel is nonzero, readback keeps stored values
    if ((nxt_s.pwr != cipc_pkg::PWR_RUN) && (nxt_s.drv_sel != 2'h0))
    begin
      nxt_s.cn_out = nxt_s.cn_gs | 8'h88;
      nxt_s.mn_out = nxt_s.mn_gs | 8'h88;
      nxt_s.cp_out = nxt_s.cp_gs | 6'h20;
      nxt_s.mp_out = nxt_s.mp_gs | 6'h20;
    end

    // read data stands only in the cycle after the strobe
    nxt_s.rdata = 8'h00;
    if (rd_en)
    begin
      case (addr)
        `CIPC_OFS_COMMAND:
          nxt_s.rdata = {3'h0, s_ff.pwr != cipc_pkg::PWR_RUN, s_ff.cmd};
        `CIPC_OFS_COMM_IEN: nxt_s.rdata = {1'b0, s_ff.comm_ien};
        `CIPC_OFS_MISC_IEN: nxt_s.rdata = {3'h0, s_ff.misc_ien};
        `CIPC_OFS_COMM_EVENT: nxt_s.rdata = {1'b0, s_ff.comm_ev};
        `CIPC_OFS_MISC_EVENT: nxt_s.rdata = {3'h0, s_ff.misc_ev};
        `CIPC_OFS_ERROR: nxt_s.rdata = error_reg;
        `CIPC_OFS_STATUS:
          nxt_s.rdata = {2'h0, s_ff.pwr != cipc_pkg::PWR_RUN, s_ff.lo_sum,
            s_ff.hi_sum, s_ff.crc_ready, hi_alert, lo_alert};
        `CIPC_OFS_WATERMARK: nxt_s.rdata = {2'h0, s_ff.watermark};
        `CIPC_OFS_BIT_FRAMING: nxt_s.rdata = {s_ff.start_send, 7'h00};
        `CIPC_OFS_TX_CONTROL: nxt_s.rdata = {6'h00, s_ff.drv_en};
        `CIPC_OFS_DRV_SELECT: nxt_s.rdata = {2'h0, s_ff.drv_sel, 4'h0};
        `CIPC_OFS_TX_AUTO: nxt_s.rdata = {2'h0, s_ff.auto_wake, 5'h00};
        `CIPC_OFS_CARRIER_N: nxt_s.rdata = s_ff.cn_gs;
        `CIPC_OFS_MOD_N: nxt_s.rdata = s_ff.mn_gs;
        `CIPC_OFS_CARRIER_P: nxt_s.rdata = {2'h0, s_ff.cp_gs};
        `CIPC_OFS_MOD_P: nxt_s.rdata = {2'h0, s_ff.mp_gs};
        default: nxt_s.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; contents survive both power-downs
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      s_ff <= RST_S;
    else
      s_ff <= nxt_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, straight from the state register
  assign rdata = s_ff.rdata;
  assign high_prio_summary = s_ff.hi_sum;
  assign low_prio_summary = s_ff.lo_sum;
  assign checksum_ready = s_ff.crc_ready;
  assign active_cmd = s_ff.cmd;
  assign cmd_start = s_ff.start;
  assign cmd_abort = s_ff.abort;
  assign cmd_run = s_ff.run;
  assign driver_field_on = s_ff.drv_out;
  assign carrier_n_conductance = s_ff.cn_out;
  assign mod_n_conductance = s_ff.mn_out;
  assign carrier_p_conductance = s_ff.cp_out;
  assign mod_p_conductance = s_ff.mp_out;
  assign units_on = s_ff.units_on;
  assign level_detector_on = s_ff.det_on;
  assign receiver_on = s_ff.units_on;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_timer_flag_set: assert property (
    (ev_on && s_ff.timer_prev == 16'h0001 && timer_value == 16'h0000)
    |=> s_ff.comm_ev[`CIPC_EV_TIMER])
    else $error("timer flag not set on one to zero");

  a_tx_flag_set: assert property (
    (ev_on && s_ff.payload_prev && tx_in_eof) |=> s_ff.comm_ev[`CIPC_EV_TX])
    else $error("tx flag not set at end of payload");

  a_high_summary_or: assert property (
    high_prio_summary == |(s_ff.comm_ev & s_ff.comm_ien & `CIPC_HI_COMM_MASK))
    else $error("high summary does not match its flags");

  a_low_summary_or: assert property (
    low_prio_summary == (|(s_ff.comm_ev & s_ff.comm_ien & `CIPC_LO_COMM_MASK)
      | |(s_ff.misc_ev & s_ff.misc_ien & `CIPC_LO_MISC_MASK)))
    else $error("low summary does not match its flags");

  a_hard_pd_off: assert property (
    !reset_powerdown_n |=> (!units_on && !level_detector_on))
    else $error("blocks still on in hard power-down");

  a_pd_enter_now: assert property (
    (s_ff.pwr == cipc_pkg::PWR_RUN && cmd_wr && wdata[`CIPC_CMD_PD_BIT])
    |=> (s_ff.pwr == cipc_pkg::PWR_DOWN && !units_on && level_detector_on == $past(reset_powerdown_n)))
    else $error("power-down not entered at once");

  a_pd_exit_count: assert property (
    (s_ff.pwr == cipc_pkg::PWR_RUN && $past(s_ff.pwr == cipc_pkg::PWR_EXIT)
      && !$past(s_ff.auto_wake && misc_set[`CIPC_DV_FIELD_ON]))
    |-> $past(s_ff.exit_cnt) == EXIT_LAST)
    else $error("power-down left before the full wait");

  a_pd_exit_start: assert property (
    (s_ff.pwr == cipc_pkg::PWR_DOWN && cmd_wr && !wdata[`CIPC_CMD_PD_BIT]
      && !(s_ff.auto_wake && misc_set[`CIPC_DV_FIELD_ON]))
    |=> (s_ff.pwr == cipc_pkg::PWR_EXIT && s_ff.exit_cnt == 11'h000) ##1 !units_on)
    else $error("exit wait not started from zero");

  a_cmd_abort_new: assert property (
    (cmd_wr && wdata[3:0] != `CIPC_CMD_NO_CHANGE && s_ff.cmd != `CIPC_CMD_IDLE)
    |=> (cmd_abort && active_cmd == $past(wdata[3:0])) ##1 (!cmd_abort || $past(cmd_wr)))
    else $error("running command not aborted by new code");

  a_idle_on_done: assert property (
    (ev_on && cmd_done && !cmd_wr && s_ff.cmd != `CIPC_CMD_IDLE)
    |=> (active_cmd == `CIPC_CMD_IDLE && s_ff.comm_ev[`CIPC_EV_IDLE]))
    else $error("finished command did not raise idle flag");

  a_force_msb_pd: assert property (
    (s_ff.pwr != cipc_pkg::PWR_RUN && s_ff.drv_sel != 2'h0)
    |-> (carrier_n_conductance[7] && carrier_n_conductance[3] && mod_n_conductance[7]
      && mod_n_conductance[3] && carrier_p_conductance[5] && mod_p_conductance[5]))
    else $error("conductance msbs not forced in power-down");

  a_transceive_wait: assert property (
    (cmd_run && active_cmd == `CIPC_CMD_TRANSCEIVE) |-> s_ff.start_send)
    else $error("transceive running without start-send");

endmodule

// file: cipc_defines.svh
// register offsets, field positions, command codes and counts of the contactless control block
//
// Functional notes
// - timer flag on counter step one to zero
// - tx flag when payload ends, eof begins
// - checksum flag and ready when fifo consumed
// - rx flag on end of received stream
// - idle flag when command returns to idle
// - nearly-full flag on high alert rising
// - nearly-empty flag on low alert rising
// - field-on and field-off flags from detector
// - error flag when any error bit set
// - mode flag when data mode detected
// - high summary: tx, rx, full, empty
// - low summary: the seven other flags
// - hard power-down pin stops every block
// - power-down bit stops all but oscillator, detector
// - registers and fifo kept during power-down
// - auto-wake on field leaves power-down
// - exit after 1024 clocks, bit self-clears
// - force conductance msbs in power-down (code forces them only while drv_sel is nonzero)
// - driver enables off: field off, receiver on
// - stream commands run at once, transceive waits
// - fixed-argument commands wait for exact count
// - fifo not flushed at command start
// - new command code aborts running command
// - idle code 0000 cancels current command
// - high alert: 64 minus fill <= watermark
// - low alert: fill <= watermark
`ifndef CIPC_DEFINES_SVH
`define CIPC_DEFINES_SVH

// register offsets
`define CIPC_OFS_COMMAND 6'h01
`define CIPC_OFS_COMM_IEN 6'h02
`define CIPC_OFS_MISC_IEN 6'h03
`define CIPC_OFS_COMM_EVENT 6'h04
`define CIPC_OFS_MISC_EVENT 6'h05
`define CIPC_OFS_ERROR 6'h06
`define CIPC_OFS_STATUS 6'h07
`define CIPC_OFS_WATERMARK 6'h0B
`define CIPC_OFS_BIT_FRAMING 6'h0D
`define CIPC_OFS_TX_CONTROL 6'h14
`define CIPC_OFS_DRV_SELECT 6'h16
`define CIPC_OFS_TX_AUTO 6'h17
`define CIPC_OFS_CARRIER_N 6'h18
`define CIPC_OFS_MOD_N 6'h19
`define CIPC_OFS_CARRIER_P 6'h1A
`define CIPC_OFS_MOD_P 6'h1B

// comm_event_reg / enable bit positions
`define CIPC_EV_TIMER 0
`define CIPC_EV_ERROR 1
`define CIPC_EV_LO 2
`define CIPC_EV_HI 3
`define CIPC_EV_IDLE 4
`define CIPC_EV_RX 5
`define CIPC_EV_TX 6
// misc_event_reg / enable bit positions
`define CIPC_DV_FIELD_OFF 0
`define CIPC_DV_FIELD_ON 1
`define CIPC_DV_CHECKSUM 2
`define CIPC_DV_MODE 4
// set/clear select bit of event register writes
`define CIPC_EV_SET_BIT 7
// group masks for the two summary bits
`define CIPC_HI_COMM_MASK 7'h6C
`define CIPC_LO_COMM_MASK 7'h13
`define CIPC_LO_MISC_MASK 5'h17
// command register fields
`define CIPC_CMD_PD_BIT 4
`define CIPC_CMD_IDLE 4'h0
`define CIPC_CMD_CONFIG 4'h1
`define CIPC_CMD_NO_CHANGE 4'h7
`define CIPC_CMD_TRANSCEIVE 4'hC
`define CIPC_CONFIG_ARGS 7'h19
// other single bits
`define CIPC_START_SEND_BIT 7
`define CIPC_AUTO_WAKE_BIT 5
// power-down exit wait in clocks of the unit
`define CIPC_PD_EXIT_CYCLES 1024
`define CIPC_FIFO_DEPTH 7'h40

`endif

// file: cipc_pkg.sv
// types of the contactless control block
package cipc_pkg;

  // power state, one-hot
  typedef enum logic [2:0]
  {
    PWR_RUN = 3'h1,
    PWR_DOWN = 3'h2,
    PWR_EXIT = 3'h4
  } cipc_pwr_t;

  // whole state of the block
  typedef struct packed
  {
    logic [3:0] cmd;
    cipc_pwr_t pwr;
    logic [10:0] exit_cnt;
    logic [6:0] comm_ev;
    logic [4:0] misc_ev;
    logic [6:0] comm_ien;
    logic [4:0] misc_ien;
    logic [5:0] watermark;
    logic start_send;
    logic [1:0] drv_en;
    logic [1:0] drv_sel;
    logic auto_wake;
    logic [7:0] cn_gs;
    logic [7:0] mn_gs;
    logic [5:0] cp_gs;
    logic [5:0] mp_gs;
    logic [15:0] timer_prev;
    logic payload_prev;
    logic rx_end_prev;
    logic crc_prev;
    logic hi_prev;
    logic lo_prev;
    logic field_prev;
    logic err_prev;
    logic mode_prev;
    logic [7:0] rdata;
    logic hi_sum;
    logic lo_sum;
    logic start;
    logic abort;
    logic run;
    logic [1:0] drv_out;
    logic [7:0] cn_out;
    logic [7:0] mn_out;
    logic [5:0] cp_out;
    logic [5:0] mp_out;
    logic units_on;
    logic det_on;
    logic crc_ready;
  } cipc_state_t;

endpackage

// file: cipc_cpu_model.sv
// processor core model: drives the register port of the contactless unit
`timescale 1ns/100ps

module cipc_cpu_model
(
  input wire logic ref_clk,
  input wire logic [7:0] rdata,
  output logic [5:0] addr,
  output logic [7:0] wdata,
  output logic wr_en,
  output logic rd_en
);
  // bus quiet from time zero, no strobe before the first call
  initial
  begin
    addr = 6'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  ////////////////////////////////////////
  // one-cycle write; firmware starts a command this way too
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  // one-cycle read; data stand only in the next cycle, so take them mid-cycle
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask
endmodule

// file: contactless_irq_power_cmd_ctrl_test.sv
// self-checking bench of the contactless event, power and command block
`timescale 1ns/100ps

module contactless_irq_power_cmd_ctrl_test;
  localparam int PD = 8; // short exit wait keeps the run brief
  // expected flag per source, and which sources are high priority
  localparam logic [7:0] EXP [10] = '{8'h01, 8'h40, 8'h20, 8'h02, 8'h08, 8'h04, 8'h04,
    8'h02, 8'h01, 8'h10};
  localparam logic [9:0] HI_GRP = 10'h036;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reset_powerdown_n = 1'b1;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [7:0] error_reg = 8'h00;
  logic wr_en, rd_en, tx_in_payload = 1'b0, tx_in_eof = 1'b0, rx_stream_end = 1'b0;
  logic crc_fifo_consumed = 1'b0, field_present = 1'b0, mode_detected = 1'b0, cmd_done = 1'b0;
  logic [15:0] timer_value = 16'h0005;
  logic [6:0] fifo_level = 7'h00;
  logic high_prio_summary, low_prio_summary, checksum_ready, cmd_start, cmd_abort, cmd_run;
  logic units_on, level_detector_on, receiver_on;
  logic [3:0] active_cmd;
  logic [1:0] driver_field_on;
  logic [7:0] carrier_n_conductance, mod_n_conductance;
  logic [5:0] carrier_p_conductance, mod_p_conductance;
  logic [31:0] seed = 32'hE639; // fixed start keeps runs repeatable
  int errors = 0, check_count = 0, n;

  cipc_cpu_model cpu
  (
    .ref_clk, .rdata, .addr, .wdata, .wr_en, .rd_en
  );

  cipc_ctrl #(.PD_EXIT_CYCLES(PD)) dut
  (
    .ref_clk, .rst, .reset_powerdown_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .timer_value, .tx_in_payload, .tx_in_eof, .rx_stream_end, .crc_fifo_consumed,
    .fifo_level, .field_present, .error_reg, .mode_detected, .cmd_done,
    .high_prio_summary, .low_prio_summary, .checksum_ready, .active_cmd, .cmd_start,
    .cmd_abort, .cmd_run, .driver_field_on, .carrier_n_conductance, .mod_n_conductance,
    .carrier_p_conductance, .mod_p_conductance, .units_on, .level_detector_on, .receiver_on
  );

  // 25 MHz unit clock
  always #20 ref_clk = ~ref_clk;

  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // registered outputs need two edges; look mid-cycle to stay off the edge
  task automatic look;
    tick(2);
    @(negedge ref_clk);
  endtask

  // drive one event source; the timer idles at 1 so only source 0 steps to 0
  task automatic fire(input int i);
    timer_value <= 16'h0001;
    tx_in_payload <= (i == 1);
    tick(1);
    timer_value <= (i == 0) ? 16'h0000 : 16'h0001;
    tx_in_payload <= 1'b0;
    tx_in_eof <= (i == 1);
    rx_stream_end <= (i == 2);
    error_reg <= (i == 3) ? 8'h04 : 8'h00;
    if (i == 4) fifo_level <= 7'h3C;
    if (i == 5) fifo_level <= 7'h00;
    crc_fifo_consumed <= (i == 6);
    if (i == 7 || i == 8) field_present <= (i == 7);
    mode_detected <= (i == 9);
    tick(1);
    timer_value <= 16'h0001;
    {tx_in_eof, rx_stream_end, crc_fifo_consumed, mode_detected} <= 4'h0;
    error_reg <= 8'h00;
    tick(2);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////
  // hang guard, far beyond the few hundred cycles the tests take
  initial
  begin
    tick(5000);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop;
  end

  initial
  begin
    tick(5);
    rst <= 1'b0;
    look;
    chk({units_on, level_detector_on, high_prio_summary, low_prio_summary, 4'h0}, 8'hC0);
    cpu.wr(6'h02, 8'h7F);
    cpu.wr(6'h03, 8'h1F);
    cpu.wr(6'h0B, 8'h08);
    // every source once; a level left high must not re-set a cleared flag
    for (int i = 0; i < 10; i++)
    begin
      cpu.wr(6'h04, 8'h7F);
      cpu.wr(6'h05, 8'h1F);
      fire(i);
      cpu.rd((i < 6) ? 6'h04 : 6'h05, d);
      chk(d, EXP[i]);
      chk({checksum_ready, high_prio_summary, low_prio_summary}, {i == 6, HI_GRP[i], !HI_GRP[i]});
      cpu.wr(6'h04, 8'h7F);
      cpu.wr(6'h05, 8'h1F);
      look;
      chk({high_prio_summary, low_prio_summary}, 8'h00);
    end
    // random fill and watermark, clamped to a legal fill of 0..64
    for (int k = 0; k < 8; k++)
    begin
      tick(1);
      seed = lfsr(seed);
      fifo_level <= (seed[6:0] > 7'h40) ? 7'h40 : seed[6:0];
      cpu.wr(6'h0B, {2'b00, seed[13:8]});
      cpu.rd(6'h07, d);
      chk(d & 8'h03, {(7'h40 - fifo_level) <= seed[13:8], fifo_level <= seed[13:8]});
    end
    tick(1);
    fifo_level <= 7'h00;
    cpu.wr(6'h01, 8'h0C);
    @(negedge ref_clk);
    chk({cmd_start, cmd_abort, 2'b00, active_cmd}, 8'h8C);
    look;
    chk({cmd_run, 3'h0, active_cmd}, 8'h0C);
    cpu.wr(6'h0D, 8'h80);
    look;
    chk({cmd_run, 3'h0, active_cmd}, 8'h8C);
    cpu.wr(6'h01, 8'h00);
    @(negedge ref_clk);
    chk({cmd_start, cmd_abort, 2'b00, active_cmd}, 8'h40);
    // config holds until exactly its argument count sits in the fifo
    tick(1);
    fifo_level <= 7'h18;
    cpu.wr(6'h01, 8'h01);
    look;
    chk({cmd_run, 3'h0, active_cmd}, 8'h01);
    tick(1);
    fifo_level <= 7'h19;
    look;
    chk({cmd_run, 3'h0, active_cmd}, 8'h81);
    // the no-change code neither starts nor aborts anything
    cpu.wr(6'h01, 8'h07);
    @(negedge ref_clk);
    chk({cmd_start, cmd_abort, 2'b00, active_cmd}, 8'h01);
    cpu.wr(6'h04, 8'h7F);
    cmd_done <= 1'b1;
    tick(1);
    cmd_done <= 1'b0;
    cpu.rd(6'h04, d);
    chk({d[4], 3'h0, active_cmd}, 8'h80);
    // transmitter power-down leaves the receiver running
    for (int v = 3; v >= 0; v -= 3)
    begin
      cpu.wr(6'h14, 8'(v));
      look;
      chk({driver_field_on, 5'h00, receiver_on}, {v[1:0], 6'h01});
    end
    cpu.wr(6'h16, 8'h10);
    cpu.wr(6'h18, 8'h55);
    cpu.wr(6'h1A, 8'h05);
    cpu.wr(6'h01, 8'h10);
    look;
    chk({units_on, level_detector_on, 6'h00}, 8'h40);
    chk(carrier_n_conductance, 8'hDD);
    chk({2'b00, carrier_p_conductance}, 8'h25);
    chk(mod_n_conductance, 8'h88);
    chk({2'b00, mod_p_conductance}, 8'h20);
    cpu.rd(6'h18, d);
    chk(d, 8'h55);
    cpu.wr(6'h01, 8'h00);
    cpu.rd(6'h01, d);
    chk(d & 8'h10, 8'h10);
    n = 2;
    while (units_on !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      n++;
      @(negedge ref_clk);
    end
    chk(8'(n), 8'(PD));
    cpu.rd(6'h01, d);
    chk(d & 8'h10, 8'h00);
    cpu.wr(6'h17, 8'h20);
    cpu.wr(6'h01, 8'h10);
    tick(2);
    field_present <= 1'b1;
    look;
    chk({units_on, 7'h00}, 8'h80);
    // hard power-down stops detection too
    cpu.wr(6'h04, 8'h7F);
    reset_powerdown_n <= 1'b0;
    look;
    chk({units_on, level_detector_on, receiver_on, 5'h00}, 8'h00);
    tick(1);
    fire(0);
    cpu.rd(6'h04, d);
    chk(d & 8'h01, 8'h00);
    tick(1);
    reset_powerdown_n <= 1'b1;
    look;
    chk({units_on, level_detector_on, receiver_on, 5'h00}, 8'hE0);
    cpu.rd(6'h3F, d);
    chk(d, 8'h00);
    report_and_stop;
  end
endmodule
